// file: design/ashp_pkg.sv
// package of constants for the converter serial host port
// assumes a 25 MHz system clock; oscillator periods are counted as system cycles
package ashp_pkg;
   localparam int unsigned CLK_HZ           = 25000000;
   localparam int unsigned OSC_HZ           = 4096000;
   localparam int unsigned WORD_BITS        = 24;
   localparam int unsigned CMD_BITS         = 8;
   // oscillator periods
   localparam int unsigned RESET_MIN_OSC    = 4;
   localparam int unsigned READY_HIGH_OSC   = 3;
   localparam int unsigned START_MIN_OSC    = 3;
   localparam int unsigned QUIET_MIN_OSC    = 5;
   // post_reset_wait in microseconds
   localparam int unsigned POST_RESET_US    = 600;
   // system cycles per oscillator period, rounded up for least times
   localparam int unsigned OSC_CYC = (CLK_HZ + OSC_HZ - 1) / OSC_HZ;
   localparam int unsigned READY_HIGH_CYC   = READY_HIGH_OSC * OSC_CYC;
   localparam int unsigned START_MIN_CYC    = START_MIN_OSC * OSC_CYC;
   localparam int unsigned RESET_MIN_CYC    = RESET_MIN_OSC * OSC_CYC;
   localparam int unsigned QUIET_MIN_CYC    = QUIET_MIN_OSC * OSC_CYC;
   localparam int unsigned POST_RESET_CYC   = (CLK_HZ / 1000000) * POST_RESET_US;
   localparam int unsigned CONV_CYC_DEF     = 20000;
   // low cycles on the clock pin before it counts as tied to digital_ground
   localparam int unsigned EXT_IDLE_CYC     = 32;
   // command byte that asks for a single conversion
   localparam logic [7:0]  CMD_CONVERT      = 8'h08;
   localparam logic [7:0]  CMD_MODE_READY   = 8'h0E;
   localparam logic [7:0]  CMD_MODE_PLAIN   = 8'h0F;
   localparam logic [7:0]  CMD_RESET        = 8'h06;
   // conversion state machine, one-hot
   typedef enum logic [3:0] {
      ASHP_WAKE  = 4'h1,
      ASHP_SLEEP = 4'h2,
      ASHP_CONV  = 4'h4,
      ASHP_GAP   = 4'h8
   } ashp_state_t;
endpackage : ashp_pkg

// file: design/ashp_link_if.sv
// interface between the core and the serial shifter
// the shifter runs on the serial clock, so the word and event crossings pass between the core clock and sclk
`timescale 1ns/1ps
interface ashp_link_if;
   logic [23:0] result;
   logic        load_tgl;
   logic        cmd_tgl;
   logic [7:0]  cmd;
   logic        rst;
   modport core (output result, output load_tgl, output rst, input cmd_tgl, input cmd);
   modport shift (input result, input load_tgl, input rst, output cmd_tgl, output cmd);
endinterface : ashp_link_if

// file: design/ashp_shifter.sv
// serial shifter clocked by the link's serial clock
// assumes the serial clock only runs while chip select is low
`timescale 1ns/1ps
module ashp_shifter
   import ashp_pkg::*;
(
   input  wire logic   sclk_i,
   input  wire logic   cs_n_i,
   input  wire logic   din_i,
   output logic        dout_o,
   ashp_link_if.shift  lnk
);
   logic [23:0] shreg;
   logic [7:0]  rxreg;
   logic [2:0]  bitcnt;
   logic        load_seen;
   logic        cmd_tgl_r;
   logic [7:0]  cmd_r;
   // ------------------------------------------------------------
   // output shift on rising edge
   // ------------------------------------------------------------
   // the result word is steady whenever the first rising edge takes it; the core only
   // changes it while the host keeps the clock quiet
   always_ff @(posedge sclk_i or posedge cs_n_i)
   begin
      if (cs_n_i)
      begin
         shreg     <= 24'h000000;
         load_seen <= 1'b0;
      end
      else if (!load_seen)
      begin
         shreg     <= {lnk.result[22:0], 1'b0};
         load_seen <= 1'b1;
      end
      else
      begin
         shreg     <= {shreg[22:0], 1'b0};
      end
   end
   // first bit shows before the first edge, then shifted bits
   assign dout_o = load_seen ? shreg[23] : lnk.result[23];
   // ------------------------------------------------------------
   // input capture on falling edge
   // ------------------------------------------------------------
   always_ff @(negedge sclk_i or posedge cs_n_i)
   begin
      if (cs_n_i)
      begin
         rxreg  <= 8'h00;
         bitcnt <= 3'h0;
      end
      else
      begin
         rxreg  <= {rxreg[6:0], din_i};
         bitcnt <= bitcnt + 3'h1;
      end
   end
   // system reset clears the toggle while the serial clock stands still, so the
   // core never sees a false command; cs cannot clear it without a false toggle
   always_ff @(negedge sclk_i or posedge lnk.rst)
   begin
      if (lnk.rst)
      begin
         cmd_r     <= 8'h00;
         cmd_tgl_r <= 1'b0;
      end
      else if (!cs_n_i && bitcnt == 3'h7)
      begin
         cmd_r     <= {rxreg[6:0], din_i};
         cmd_tgl_r <= ~cmd_tgl_r;
      end
   end
   assign lnk.cmd     = cmd_r;
   assign lnk.cmd_tgl = cmd_tgl_r;
endmodule : ashp_shifter

// file: design/ashp_core.sv
// converter serial host port: reset, start, data ready, serial output
// assumes pins are asynchronous to clk_i; the serial clock is a second domain
`timescale 1ns/1ps
module ashp_core
   import ashp_pkg::*;
#(
   parameter int unsigned CONV_CYC = CONV_CYC_DEF
)
(
   input  wire logic        clk_i,
   input  wire logic        sys_rst_i,
   input  wire logic        sclk_i,
   input  wire logic        ext_clk_i,
   input  wire logic        chip_rst_n_i,
   input  wire logic        start_i,
   input  wire logic        cs_n_i,
   input  wire logic        din_i,
   input  wire logic [23:0] sample_i,
   output logic             data_ready_n_o,
   output logic             serial_out_with_ready_o,
   output logic             serial_out_oe_n_o,
   output logic             use_internal_osc_o,
   output logic             sleeping_o
);
   ashp_link_if lnk ();
   logic        sh_dout;
   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   logic [1:0] s_rst;
   logic [1:0] s_start;
   logic [1:0] s_cs;
   logic [1:0] s_eclk;
   logic [2:0] s_cmd;
   logic [1:0] s_shd;
   logic       cmd_prev;
   always_ff @(posedge clk_i)
   begin
      s_rst   <= {s_rst[0], chip_rst_n_i};
      s_start <= {s_start[0], start_i};
      s_cs    <= {s_cs[0], cs_n_i};
      s_eclk  <= {s_eclk[0], ext_clk_i};
      s_cmd   <= {s_cmd[1:0], lnk.cmd_tgl};
      s_shd   <= {s_shd[0], sh_dout};
   end
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   ashp_state_t state, next_state;
   logic [31:0] cnt, next_cnt;
   logic [15:0] rst_cnt, next_rst_cnt;
   logic [15:0] st_cnt, next_st_cnt;
   logic [15:0] quiet_cnt, next_quiet_cnt;
   logic        ready_mode, next_ready_mode;
   logic        rdy_n, next_rdy_n;
   logic        pending, next_pending;
   logic [23:0] result, next_result;
   logic        load_tgl, next_load_tgl;
   logic        ser_o, next_ser_o;
   logic        oe_n, next_oe_n;
   logic        int_osc, next_int_osc;
   logic        sleep_r, next_sleep_r;
   logic [7:0]  eclk_idle, next_eclk_idle;
   logic        chip_rst;
   logic        start_req;
   logic        cmd_ev;
   assign chip_rst  = (rst_cnt >= 16'(RESET_MIN_CYC));
   assign start_req = (st_cnt == 16'(START_MIN_CYC));
   assign cmd_ev    = (s_cmd[2] != cmd_prev);
   always_comb
   begin
      next_state      = state;
      next_cnt        = cnt;
      next_rst_cnt    = s_rst[1] ? 16'h0000 : (chip_rst ? rst_cnt : rst_cnt + 16'h0001);
      // counting one past the threshold makes a long start pulse count once
      next_st_cnt     = s_start[1] ? ((st_cnt == 16'(START_MIN_CYC + 1)) ? st_cnt
                                      : st_cnt + 16'h0001) : 16'h0000;
      next_quiet_cnt  = (!s_cs[1] && s_cmd[1] == s_cmd[2]) ?
                        ((quiet_cnt == 16'hFFFF) ? quiet_cnt : quiet_cnt + 16'h0001) : 16'h0000;
      next_ready_mode = ready_mode;
      next_rdy_n      = rdy_n;
      next_pending    = pending;
      next_result     = result;
      next_load_tgl   = load_tgl;
      // a running external clock keeps clearing this, a tied-low pin lets it fill
      next_eclk_idle  = s_eclk[1] ? 8'h00 :
                        ((eclk_idle == 8'(EXT_IDLE_CYC)) ? eclk_idle : eclk_idle + 8'h01);
      next_int_osc    = (eclk_idle == 8'(EXT_IDLE_CYC));
      next_sleep_r    = (state == ASHP_SLEEP);
      case (state)
         ASHP_WAKE:
         begin
            next_state = ASHP_SLEEP;
         end
         ASHP_SLEEP:
         begin
            if (pending)
            begin
               next_pending = 1'b0;
               next_cnt     = 32'(CONV_CYC);
               next_state   = ASHP_CONV;
            end
         end
         ASHP_CONV:
         begin
            if (cnt != 32'h0)
               next_cnt = cnt - 32'h1;
            else if (s_cs[1] || quiet_cnt >= 16'(QUIET_MIN_CYC))
            begin
               next_rdy_n = 1'b1;
               next_cnt   = 32'(READY_HIGH_CYC);
               next_state = ASHP_GAP;
            end
         end
         ASHP_GAP:
         begin
            if (cnt != 32'h0)
               next_cnt = cnt - 32'h1;
            else
            begin
               next_result   = sample_i;
               next_load_tgl = ~load_tgl;
               next_rdy_n    = 1'b0;
               next_state    = ASHP_SLEEP;
            end
         end
         default: next_state = ASHP_WAKE;
      endcase
      // requests come after the state step so a new one is kept when the old is taken
      if (cmd_ev)
      begin
         case (lnk.cmd)
            CMD_CONVERT:    next_pending    = 1'b1;
            CMD_MODE_READY: next_ready_mode = 1'b1;
            CMD_MODE_PLAIN: next_ready_mode = 1'b0;
            default:        next_pending    = next_pending;
         endcase
      end
      if (start_req && st_cnt != 16'(START_MIN_CYC + 1))
         next_pending = 1'b1;
      // reading the result clears the ready flag once the host has clocked a whole byte
      if (!s_cs[1] && cmd_ev && state != ASHP_GAP)
         next_rdy_n = 1'b1;
      next_oe_n = s_cs[1];
      if (s_cs[1])
         next_ser_o = 1'b1;
      else if (ready_mode && quiet_cnt != 16'h0 && s_cmd[1] == s_cmd[2] && !cmd_ev)
         next_ser_o = s_shd[1] & rdy_n;
      else
         next_ser_o = s_shd[1];
      if (chip_rst)
      begin
         next_state      = ASHP_WAKE;
         next_ready_mode = 1'b0;
         next_pending    = 1'b0;
         next_rdy_n      = 1'b1;
         next_oe_n       = 1'b1;
      end
   end
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         state      <= ASHP_WAKE;
         cnt        <= 32'h0;
         rst_cnt    <= 16'h0000;
         st_cnt     <= 16'h0000;
         quiet_cnt  <= 16'h0000;
         ready_mode <= 1'b0;
         rdy_n      <= 1'b1;
         pending    <= 1'b0;
         result     <= 24'h000000;
         load_tgl   <= 1'b0;
         ser_o      <= 1'b1;
         oe_n       <= 1'b1;
         int_osc    <= 1'b0;
         sleep_r    <= 1'b0;
         eclk_idle  <= 8'h00;
         cmd_prev   <= 1'b0;
      end
      else
      begin
         state      <= next_state;
         cnt        <= next_cnt;
         rst_cnt    <= next_rst_cnt;
         st_cnt     <= next_st_cnt;
         quiet_cnt  <= next_quiet_cnt;
         ready_mode <= next_ready_mode;
         rdy_n      <= next_rdy_n;
         pending    <= next_pending;
         result     <= next_result;
         load_tgl   <= next_load_tgl;
         ser_o      <= next_ser_o;
         oe_n       <= next_oe_n;
         int_osc    <= next_int_osc;
         sleep_r    <= next_sleep_r;
         eclk_idle  <= next_eclk_idle;
         cmd_prev   <= s_cmd[2];
      end
   end
   assign lnk.result   = result;
   assign lnk.load_tgl = load_tgl;
   // asserted while the serial clock is idle, so its release needs no synchroniser
   assign lnk.rst      = sys_rst_i;
   assign data_ready_n_o          = rdy_n;
   assign serial_out_with_ready_o = ser_o;
   assign serial_out_oe_n_o       = oe_n;
   assign use_internal_osc_o      = int_osc;
   assign sleeping_o              = sleep_r;
   // ------------------------------------------------------------
   // serial clock domain
   // ------------------------------------------------------------
   ashp_shifter u_shift (
      .sclk_i (sclk_i),
      .cs_n_i (cs_n_i),
      .din_i  (din_i),
      .dout_o (sh_dout),
      .lnk    (lnk.shift)
   );
endmodule : ashp_core

// file: tb/ashp_core_checker.sv
// assertions on the pins of the converter serial host port
// assumes it is bound to ashp_core; pins are asynchronous to clk_i
`timescale 1ns/1ps
module ashp_core_checker
   import ashp_pkg::*;
(
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic ext_clk_i,
   input wire logic chip_rst_n_i,
   input wire logic start_i,
   input wire logic cs_n_i,
   input wire logic data_ready_n_o,
   input wire logic serial_out_oe_n_o,
   input wire logic use_internal_osc_o,
   input wire logic sleeping_o
);
   // saturating run lengths; pin synchronisers blur exact edges
   logic [7:0] hi_cnt;
   logic [7:0] ext_lo;
   logic [7:0] rst_lo;
   always_ff @(posedge clk_i)
   begin
      hi_cnt <= (sys_rst_i || !data_ready_n_o) ? 8'h00 : hi_cnt + {7'h00, hi_cnt != 8'hFF};
      ext_lo <= (sys_rst_i || ext_clk_i) ? 8'h00 : ext_lo + {7'h00, ext_lo != 8'hFF};
      rst_lo <= (sys_rst_i || chip_rst_n_i) ? 8'h00 : rst_lo + {7'h00, rst_lo != 8'hFF};
   end
   default clocking @(posedge clk_i);
   endclocking
   default disable iff (sys_rst_i);
   oe_release_a: assert property (cs_n_i [*4] |-> serial_out_oe_n_o)
      else $error("output not released with select high");
   oe_drive_a: assert property ((!cs_n_i && chip_rst_n_i) [*6] |-> !serial_out_oe_n_o)
      else $error("output not driven while selected");
   osc_select_a: assert property (ext_lo >= 8'h40 |-> use_internal_osc_o)
      else $error("internal oscillator not chosen");
   chip_reset_a: assert property (rst_lo >= 8'h28 |-> data_ready_n_o)
      else $error("ready not cleared by chip reset");
   ready_gap_a: assert property ($fell(data_ready_n_o) |-> hi_cnt >= READY_HIGH_CYC)
      else $error("ready high gap too short");
   ready_stand_a: assert property ($fell(data_ready_n_o) |=> !data_ready_n_o [*4])
      else $error("ready did not stand");
   sleep_after_a: assert property ($fell(data_ready_n_o) |-> ##[0:8] sleeping_o)
      else $error("no sleep after conversion");
   sleep_hold_a: assert property (
      (sleeping_o && !data_ready_n_o && cs_n_i && !start_i && chip_rst_n_i) [*8]
      |=> sleeping_o)
      else $error("woke without request");
endmodule : ashp_core_checker
bind ashp_core ashp_core_checker ashp_core_checker_i (.clk_i, .sys_rst_i, .ext_clk_i,
   .chip_rst_n_i, .start_i, .cs_n_i, .data_ready_n_o, .serial_out_oe_n_o,
   .use_internal_osc_o, .sleeping_o);

// file: tb/ashp_host_model.sv
// host controller on the far side of the serial link
// assumes the device shifts out after sclk rise and takes din on sclk fall
`timescale 1ns/1ps
module ashp_host_model
(
   input  wire logic dout_i,
   output logic      sclk_o,
   output logic      cs_n_o,
   output logic      din_o
);
   initial
   begin
      sclk_o = 1'b0;
      cs_n_o = 1'b1;
      din_o  = 1'b0;
   end
   // first byte carries cmd, later bytes an unused filler code
   task automatic xfer(input logic [7:0] cmd, input int nbytes, input logic keep,
                       output logic [23:0] rx);
      rx = 24'h000000;
      cs_n_o = 1'b0;
      #403;
      for (int i = 0; i < 8 * nbytes; i++)
      begin
         din_o  = (i < 8) ? cmd[7 - i] : 1'b1;
         rx     = {rx[22:0], dout_i};
         sclk_o = 1'b1;
         #80;
         sclk_o = 1'b0;
         #80;
      end
      // a released line must not keep showing its last bit
      din_o = ~din_o;
      #2000;
      if (!keep)
         cs_n_o = 1'b1;
   endtask : xfer
endmodule : ashp_host_model

// file: tb/test_ashp_core.sv
// self-checking bench of the converter serial host port
// assumes a 25 MHz clock and the host model on the serial side
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin failures++; \
   $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module test_ashp_core;
   import ashp_pkg::*;
   typedef struct packed {logic [23:0] smp; logic by_start; logic [1:0] nby; logic [23:0] exp;} ashp_row_t;
   ashp_row_t   rows [3] = '{'{24'hA5C3F0, 1'h1, 2'h3, 24'hA5C3F0},
      '{24'h000001, 1'h0, 2'h3, 24'h000001}, '{24'h7E5A81, 1'h0, 2'h1, 24'h00007E}};
   int          failures;
   int          comparisons;
   logic        clk, sys_rst, ext_clk, chip_rst_n, start, sclk, cs_n, din;
   logic        ready_n, ser, oe_n, int_osc, sleeping;
   logic [23:0] sample, rx;
   ashp_core #(.CONV_CYC(50)) ashp_core_i (.clk_i(clk), .sys_rst_i(sys_rst), .sclk_i(sclk),
      .ext_clk_i(ext_clk), .chip_rst_n_i(chip_rst_n), .start_i(start), .cs_n_i(cs_n),
      .din_i(din), .sample_i(sample), .data_ready_n_o(ready_n), .serial_out_with_ready_o(ser),
      .serial_out_oe_n_o(oe_n), .use_internal_osc_o(int_osc), .sleeping_o(sleeping));
   ashp_host_model ashp_host_model_i (.dout_i(ser), .sclk_o(sclk), .cs_n_o(cs_n), .din_o(din));
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic report_and_stop;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : report_and_stop
   task automatic wait_ready(input logic want);
      for (int n = 0; n < 2000 && ready_n !== want; n++)
         @(negedge clk);
      `CHK("data_ready_n", want, ready_n)
   endtask : wait_ready
   task automatic pulse_start;
      start = 1'b1;
      repeat (START_MIN_CYC + 4) @(negedge clk);
      start = 1'b0;
   endtask : pulse_start
   initial
   begin
      repeat (40000) @(posedge clk);
      failures++;
      report_and_stop();
   end
   // ----
   // row loop, then ready on output, clock source and chip reset
   // ----
   initial
   begin
      failures = 0;
      comparisons = 0;
      {sys_rst, ext_clk, chip_rst_n, start, sample} = {1'h1, 1'h0, 1'h1, 1'h0, 24'h000000};
      repeat (16) @(negedge clk);
      sys_rst = 1'b0;
      repeat (POST_RESET_CYC) @(negedge clk);
      `CHK("use_internal_osc", 1'b1, int_osc)
      `CHK("oe_n idle", 1'b1, oe_n)
      foreach (rows[k])
      begin
         sample = rows[k].smp;
         if (rows[k].by_start)
            pulse_start();
         else
            ashp_host_model_i.xfer(CMD_CONVERT, 1, 1'b0, rx);
         wait_ready(1'b1);
         wait_ready(1'b0);
         @(negedge clk);
         `CHK("sleeping", 1'b1, sleeping)
         ashp_host_model_i.xfer(8'hFF, rows[k].nby, 1'b0, rx);
         `CHK("word", rows[k].exp, rx)
         $display("row %0d done", k);
      end
      ashp_host_model_i.xfer(CMD_MODE_READY, 1, 1'b0, rx);
      ashp_host_model_i.xfer(CMD_CONVERT, 1, 1'b1, rx);
      wait_ready(1'b1);
      wait_ready(1'b0);
      repeat (6) @(negedge clk);
      `CHK("ready on output", 1'b0, ser)
      `CHK("oe_n selected", 1'b0, oe_n)
      ashp_host_model_i.xfer(CMD_MODE_PLAIN, 1, 1'b0, rx);
      $display("ready on output done");
      repeat (60)
      begin
         repeat (3) @(negedge clk);
         ext_clk = ~ext_clk;
      end
      `CHK("external clock", 1'b0, int_osc)
      repeat (200) @(negedge clk);
      `CHK("internal clock", 1'b1, int_osc)
      $display("clock source done");
      pulse_start();
      wait_ready(1'b1);
      wait_ready(1'b0);
      chip_rst_n = 1'b0;
      repeat (48) @(negedge clk);
      chip_rst_n = 1'b1;
      `CHK("ready after chip reset", 1'b1, ready_n)
      $display("chip reset done");
      report_and_stop();
   end
endmodule : test_ashp_core
